/* File: fpx_pkg.sv */
// fpx_pkg: shared constants for the coprocessor exception/context link
// assumes: one 125 MHz clock, synchronous active-low reset everywhere
package fpx_pkg;

  // ----------------------------------------------------------------
  // link operations
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_LOAD_CTX  = 4'h1;
  localparam logic [3:0] OP_STORE_CTX = 4'h2;
  localparam logic [3:0] OP_READ_REV  = 4'h3;
  localparam logic [3:0] OP_TO_REG    = 4'h4;
  localparam logic [3:0] OP_FROM_REG  = 4'h5;
  localparam logic [3:0] OP_SQRT      = 4'h6;
  localparam logic [3:0] OP_RSUB      = 4'h7;
  localparam logic [3:0] OP_DMAC      = 4'h8;

  // ----------------------------------------------------------------
  // control word layout
  // ----------------------------------------------------------------
  localparam int         ACC_LSB     = 8;
  localparam int         MASK_LSB    = 16;
  localparam logic [7:0] EXC_INVALID = 8'h01;
  localparam logic [4:0] REG_ONE     = 5'h01;
  localparam logic [4:0] REG_TWO     = 5'h02;
  localparam int         NUM_REGS    = 32;

  // ----------------------------------------------------------------
  // power-up words
  // ----------------------------------------------------------------
  localparam logic [31:0] W_PROBE  = 32'hB800_0000;
  localparam logic [31:0] W_BOTH   = 32'h1600_0000;
  localparam logic [31:0] W_MUL    = 32'h5600_0000;
  localparam logic [31:0] W_ALU    = 32'h9800_0000;
  localparam logic [31:0] W_TAIL0  = 32'h6400_0000;
  localparam logic [31:0] W_TAIL1  = 32'hA000_0000;
  localparam logic [31:0] W_TAIL2  = 32'h3000_0000;
  localparam logic [31:0] W_SAFE   = 32'h03FF_0000;

  // ----------------------------------------------------------------
  // controller register map (axi4-lite byte addresses)
  // ----------------------------------------------------------------
  localparam int         ADDR_W   = 9;
  localparam logic [8:0] A_CTRL   = 9'h000;
  localparam logic [8:0] A_WDATA  = 9'h004;
  localparam logic [8:0] A_RDATA  = 9'h008;
  localparam logic [8:0] A_STATUS = 9'h00C;
  localparam logic [8:0] A_ISTAT  = 9'h010;
  localparam logic [8:0] A_IMASK  = 9'h014;
  localparam logic [8:0] A_BUF    = 9'h080;
  localparam logic [2:0] GO_CMD   = 3'h1;
  localparam logic [2:0] GO_INIT  = 3'h2;
  localparam logic [2:0] GO_DET   = 3'h3;
  localparam logic [2:0] GO_SAVE  = 3'h4;
  localparam logic [2:0] GO_REST  = 3'h5;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [2:0] {M_CMD, M_INIT, M_DET, M_SAVE, M_REST} mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} seq_t;

endpackage

/* File: fpx_link_if.sv */
// fpx_link_if: operation link between host controller and coprocessor
// assumes: both ends clocked by the same i_clk
`timescale 1ns/1ps
`default_nettype none
interface fpx_link_if;
  logic        req;
  logic [3:0]  op;
  logic [4:0]  idx;
  logic [31:0] wdata;
  logic        ack;
  logic [31:0] rdata;
  logic        irq;

  modport dev (input req, op, idx, wdata, output ack, rdata, irq);
  modport hst (output req, op, idx, wdata, input ack, rdata, irq);
endinterface
`default_nettype wire

/* File: fpx_dev.sv */
// fpx_dev: coprocessor end: register file, control word, exceptions
// assumes: host holds req and payload until ack, drops req after ack
`timescale 1ns/1ps
`default_nettype none
module fpx_dev #(
  // arbitrary silicon variant code
  parameter logic [15:0] REVISION = 16'h0000
) (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  fpx_link_if.dev         link,
  input  wire logic [7:0] i_exc,
  output logic            o_arith_go,
  output logic [3:0]      o_arith_op
);

  typedef struct packed {
    logic [31:0][31:0] regs;
    logic [31:0]       ctx;
    logic              ack;
    logic [31:0]       rdata;
    logic              irq;
    logic              go;
    logic [3:0]        aop;
  } dev_state_t;

  dev_state_t s;
  dev_state_t n;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] acc_set;
    acc_set = i_exc;
    n       = s;
    n.ack   = 1'b0;
    n.go    = 1'b0;
    if (link.req && !s.ack)
    begin
      n.ack = 1'b1;
      unique case (link.op)
        fpx_pkg::OP_LOAD_CTX:  n.ctx = link.wdata;
        fpx_pkg::OP_STORE_CTX: n.rdata = s.ctx;
        fpx_pkg::OP_READ_REV:  n.rdata = {16'h0000, REVISION};
        fpx_pkg::OP_TO_REG:    n.regs[link.idx] = link.wdata;
        fpx_pkg::OP_FROM_REG:  n.rdata = s.regs[link.idx];
        fpx_pkg::OP_SQRT,
        fpx_pkg::OP_RSUB,
        fpx_pkg::OP_DMAC:
        begin
          n.go  = 1'b1;
          n.aop = link.op;
        end
        default: acc_set = acc_set | fpx_pkg::EXC_INVALID;
      endcase
    end
    // new exception beats a same-cycle clear
    n.ctx[fpx_pkg::ACC_LSB +: 8] = n.ctx[fpx_pkg::ACC_LSB +: 8] | acc_set;
    n.irq = |(n.ctx[fpx_pkg::ACC_LSB +: 8]
              & ~n.ctx[fpx_pkg::MASK_LSB +: 8]);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      s <= '0;
    else
      s <= n;
  end

  assign link.ack   = s.ack;
  assign link.rdata = s.rdata;
  assign link.irq   = s.irq;
  assign o_arith_go = s.go;
  assign o_arith_op = s.aop;

endmodule // fpx_dev
`default_nettype wire

/* File: fpx_host.sv */
// fpx_host: host-side controller driving the coprocessor link
// assumes: axi4-lite master obeys valid/ready; device answers every req
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module fpx_host (
  input  wire logic                      i_clk,
  input  wire logic                      i_resetn,
  fpx_link_if.hst                        link,
  input  wire logic                      i_other_fault,
  input  wire logic                      i_awvalid,
  input  wire logic [fpx_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                      i_wvalid,
  input  wire logic [31:0]               i_wdata,
  input  wire logic [3:0]                i_wstrb,
  input  wire logic                      i_bready,
  input  wire logic                      i_arvalid,
  input  wire logic [fpx_pkg::ADDR_W-1:0] i_araddr,
  input  wire logic                      i_rready,
  output logic                           o_awready,
  output logic                           o_wready,
  output logic                           o_bvalid,
  output logic [1:0]                     o_bresp,
  output logic                           o_arready,
  output logic                           o_rvalid,
  output logic [31:0]                    o_rdata,
  output logic [1:0]                     o_rresp,
  output logic                           o_irq,
  output logic                           o_fault_line
);

  typedef struct packed {
    logic                        awready;
    logic                        wready;
    logic                        aw_got;
    logic                        w_got;
    logic [fpx_pkg::ADDR_W-1:0]  waddr;
    logic [31:0]                 wdat;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [31:0]                 rdat;
    logic [1:0]                  rresp;
    fpx_pkg::seq_t               st;
    fpx_pkg::mode_t              mode;
    logic [5:0]                  step;
    logic [3:0]                  cop;
    logic [4:0]                  cidx;
    logic [31:0]                 cdat;
    logic [31:0]                 last;
    logic [31:0]                 tmp;
    logic                        ok1;
    logic                        present;
    logic [15:0]                 rev;
    logic [1:0]                  istat;
    logic [1:0]                  imask;
    logic                        irq;
    logic                        fault;
    logic [32:0][31:0]           sbuf;
    logic                        req;
    logic [3:0]                  op;
    logic [4:0]                  idx;
    logic [31:0]                 lwd;
  } host_state_t;

  host_state_t s;
  host_state_t n;

  // save-buffer window decode, used by read and write paths
  function automatic logic buf_hit(input logic [fpx_pkg::ADDR_W-1:0] a);
    buf_hit = (a >= fpx_pkg::A_BUF)
              && (a < fpx_pkg::A_BUF + 9'(4 * (fpx_pkg::NUM_REGS + 1)));
  endfunction

  function automatic logic [5:0] buf_idx(
    input logic [fpx_pkg::ADDR_W-1:0] a);
    logic [fpx_pkg::ADDR_W-1:0] d;
    d       = a - fpx_pkg::A_BUF;
    buf_idx = d[7:2];
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [3:0]  sop;
    logic [4:0]  sidx;
    logic [31:0] sdat;
    logic        slast;
    logic [1:0]  ev;
    logic        line;
    sop   = fpx_pkg::OP_LOAD_CTX;
    sidx  = s.step[4:0];
    sdat  = '0;
    slast = 1'b0;
    ev    = 2'b00;
    line  = 1'b0;
    n     = s;

    // operation for the current step
    unique case (s.mode)
      fpx_pkg::M_CMD:
      begin
        sop   = s.cop;
        sidx  = s.cidx;
        sdat  = s.cdat;
        slast = 1'b1;
      end
      fpx_pkg::M_INIT:
      begin
        unique case (s.step)
          6'd0: sdat = fpx_pkg::W_PROBE;
          6'd1: sop  = fpx_pkg::OP_READ_REV;
          6'd2: sdat = (s.rev[15:8] == 8'h00) ? fpx_pkg::W_BOTH
                                              : fpx_pkg::W_MUL;
          6'd3: sdat = fpx_pkg::W_ALU;
          6'd4: sdat = fpx_pkg::W_TAIL0;
          6'd5: sdat = fpx_pkg::W_TAIL1;
          6'd6: sdat = fpx_pkg::W_TAIL2;
          default:
          begin
            sdat  = fpx_pkg::W_SAFE;
            slast = 1'b1;
          end
        endcase
      end
      fpx_pkg::M_DET:
      begin
        unique case (s.step)
          6'd0:
          begin
            sop  = fpx_pkg::OP_FROM_REG;
            sidx = fpx_pkg::REG_ONE;
          end
          6'd1:
          begin
            sop  = fpx_pkg::OP_TO_REG;
            sidx = fpx_pkg::REG_TWO;
            sdat = s.tmp;
          end
          6'd2:
          begin
            sop  = fpx_pkg::OP_TO_REG;
            sidx = fpx_pkg::REG_ONE;
            sdat = ~s.tmp;
          end
          6'd3:
          begin
            sop  = fpx_pkg::OP_FROM_REG;
            sidx = fpx_pkg::REG_ONE;
          end
          default:
          begin
            sop   = fpx_pkg::OP_FROM_REG;
            sidx  = fpx_pkg::REG_TWO;
            slast = 1'b1;
          end
        endcase
      end
      fpx_pkg::M_SAVE:
      begin
        sop   = (s.step[5]) ? fpx_pkg::OP_STORE_CTX
                            : fpx_pkg::OP_FROM_REG;
        slast = s.step[5];
      end
      fpx_pkg::M_REST:
      begin
        sop  = (s.step[5]) ? fpx_pkg::OP_LOAD_CTX
                           : fpx_pkg::OP_TO_REG;
        sdat = s.sbuf[s.step];
      end
    endcase

    // link sequencer
    unique case (s.st)
      fpx_pkg::ST_IDLE: ;
      fpx_pkg::ST_ISSUE:
      begin
        n.req = 1'b1;
        n.op  = sop;
        n.idx = sidx;
        n.lwd = sdat;
        n.st  = fpx_pkg::ST_WAIT;
      end
      fpx_pkg::ST_WAIT:
      begin
        if (link.ack)
        begin
          n.req  = 1'b0;
          n.last = link.rdata;
          n.step = s.step + 6'd1;
          n.st   = fpx_pkg::ST_ISSUE;
          if (s.mode == fpx_pkg::M_INIT && s.step == 6'd1)
            n.rev = link.rdata[15:0];
          if (s.mode == fpx_pkg::M_INIT && s.step == 6'd2
              && s.rev[15:8] == 8'h00)
            n.step = 6'd4;
          if (s.mode == fpx_pkg::M_DET)
          begin
            if (s.step == 6'd0)
              n.tmp = link.rdata;
            if (s.step == 6'd3)
              n.ok1 = (link.rdata == ~s.tmp);
            if (s.step == 6'd4)
              n.present = s.ok1 && (link.rdata == s.tmp);
          end
          if (s.mode == fpx_pkg::M_SAVE)
            n.sbuf[s.step] = link.rdata;
          if (s.mode == fpx_pkg::M_REST && s.step[5])
          begin
            n.mode = fpx_pkg::M_INIT;
            n.step = '0;
          end
          else if (slast)
          begin
            n.st  = fpx_pkg::ST_IDLE;
            ev[0] = 1'b1;
          end
        end
      end
    endcase

    // axi4-lite write: address and data accepted in either order
    if (i_awvalid && s.awready)
    begin
      n.aw_got  = 1'b1;
      n.awready = 1'b0;
      n.waddr   = i_awaddr;
    end
    if (i_wvalid && s.wready)
    begin
      n.w_got  = 1'b1;
      n.wready = 1'b0;
      n.wdat   = i_wdata;
    end
    if (s.bvalid && i_bready)
    begin
      n.bvalid  = 1'b0;
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = fpx_pkg::RESP_OK;
      if (buf_hit(s.waddr))
        n.sbuf[buf_idx(s.waddr)] = s.wdat;
      else
      begin
        unique case (s.waddr)
          fpx_pkg::A_CTRL:
          begin
            if (s.st == fpx_pkg::ST_IDLE && s.wdat[2:0] != 3'h0
                && s.wdat[2:0] <= fpx_pkg::GO_REST)
            begin
              n.st   = fpx_pkg::ST_ISSUE;
              n.step = '0;
              n.cop  = s.wdat[7:4];
              n.cidx = s.wdat[12:8];
              n.mode = fpx_pkg::mode_t'(s.wdat[2:0] - 3'h1);
            end
          end
          fpx_pkg::A_WDATA: n.cdat  = s.wdat;
          fpx_pkg::A_ISTAT: n.istat = s.istat & ~s.wdat[1:0];
          fpx_pkg::A_IMASK: n.imask = s.wdat[1:0];
          default:          n.bresp = fpx_pkg::RESP_ERR;
        endcase
      end
    end

    // axi4-lite read
    if (s.rvalid && i_rready)
    begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end
    if (i_arvalid && s.arready)
    begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rresp   = fpx_pkg::RESP_OK;
      n.rdat    = '0;
      if (buf_hit(i_araddr))
        n.rdat = s.sbuf[buf_idx(i_araddr)];
      else
      begin
        unique case (i_araddr)
          fpx_pkg::A_WDATA:  n.rdat = s.cdat;
          fpx_pkg::A_RDATA:  n.rdat = s.last;
          fpx_pkg::A_STATUS: n.rdat = {s.rev, 13'h0000, s.fault,
                                       s.present, s.st != fpx_pkg::ST_IDLE};
          fpx_pkg::A_ISTAT:  n.rdat = {30'h0000_0000, s.istat};
          fpx_pkg::A_IMASK:  n.rdat = {30'h0000_0000, s.imask};
          default:           n.rresp = fpx_pkg::RESP_ERR;
        endcase
      end
    end

    // shared fault line and interrupt; set beats clear
    line    = link.irq | i_other_fault;
    ev[1]   = line && !s.fault;
    n.fault = line;
    n.istat = n.istat | ev;
    n.irq   = |(n.istat & n.imask);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      s         <= '0;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end
    else
      s <= n;
  end

  assign link.req     = s.req;
  assign link.op      = s.op;
  assign link.idx     = s.idx;
  assign link.wdata   = s.lwd;
  assign o_awready    = s.awready;
  assign o_wready     = s.wready;
  assign o_bvalid     = s.bvalid;
  assign o_bresp      = s.bresp;
  assign o_arready    = s.arready;
  assign o_rvalid     = s.rvalid;
  assign o_rdata      = s.rdat;
  assign o_rresp      = s.rresp;
  assign o_irq        = s.irq;
  assign o_fault_line = s.fault;

endmodule // fpx_host
`default_nettype wire

/* File: fpx_props.sv */
// fpx_props: checker watching the coprocessor link signals
// assumes: one clock, sync active-low reset, instanced beside the link
`timescale 1ns/1ps
`default_nettype none
module fpx_props #(
  parameter logic [15:0] REVISION = 16'h0000
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        req,
  input  wire logic [3:0]  op,
  input  wire logic [4:0]  idx,
  input  wire logic [31:0] wdata,
  input  wire logic        ack,
  input  wire logic [31:0] rdata,
  input  wire logic        irq
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  wire logic       take = req && !ack;
  wire logic       ld   = take && op == fpx_pkg::OP_LOAD_CTX;
  wire logic [7:0] live = wdata[fpx_pkg::ACC_LSB +: 8]
                          & ~wdata[fpx_pkg::MASK_LSB +: 8];

  // ------
  // handshake
  // ------
  a_ack_follows: assert property (take |=> ack)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(ack) |-> $past(take))
    else $error("ack without request");
  a_req_held: assert property (take |=>
    req && $stable(op) && $stable(idx) && $stable(wdata))
    else $error("request changed before ack");
  a_req_release: assert property (ack |=> !req)
    else $error("request not dropped after ack");
  a_rdata_hold: assert property (!take |=> $stable(rdata))
    else $error("read data moved without request");

  // ------
  // revision and exceptions
  // ------
  a_rev_value: assert property (
    ack && op == fpx_pkg::OP_READ_REV |-> rdata[15:0] == REVISION)
    else $error("wrong revision value");
  a_irq_live: assert property (ld && live != 8'h00 |-> ##[1:3] irq)
    else $error("enabled exception gave no request");
  a_irq_quiet: assert property (ld && live == 8'h00 |-> ##[1:3] !irq)
    else $error("request stays with nothing enabled");
  a_irq_fall: assert property ($fell(irq) |-> $past(req) || $past(req, 2))
    else $error("request fell without a load");

  c_rev: cover property (ack && op == fpx_pkg::OP_READ_REV);
  c_irq: cover property ($rose(irq));
  c_dmac: cover property (take && op == fpx_pkg::OP_DMAC);
endmodule // fpx_props
`default_nettype wire

/* File: test_fpu_exception_context_control.sv */
// test_fpu_exception_context_control: bench for host and device ends
// assumes: fpx_pkg, fpx_link_if, fpx_dev, fpx_host, fpx_props compiled
`timescale 1ns/1ps
`default_nettype none
module test_fpu_exception_context_control;
  localparam logic [15:0] REV = 16'h0000; // arbitrary variant code
  logic        i_clk;
  logic        i_resetn;
  logic [7:0]  exc;
  logic        other, awvalid, wvalid, arvalid, go;
  logic [8:0]  awaddr, araddr;
  logic [31:0] wdat, rdat;
  logic        awready, wready, bvalid, arready, rvalid, irq, fault;
  logic [1:0]  bresp, rresp;
  logic [3:0]  go_op;
  int          n_errors, cmp_count, n_go;
  logic [31:0] loads[$];

  fpx_link_if link();
  fpx_dev #(.REVISION(REV)) fpx_dev_i (.i_clk(i_clk), .i_resetn(i_resetn),
    .link(link), .i_exc(exc), .o_arith_go(go), .o_arith_op(go_op));
  fpx_host fpx_host_i (.i_clk(i_clk), .i_resetn(i_resetn), .link(link),
    .i_other_fault(other), .i_awvalid(awvalid), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .i_wdata(wdat), .i_wstrb(4'hF), .i_bready(1'b1),
    .i_arvalid(arvalid), .i_araddr(araddr), .i_rready(1'b1),
    .o_awready(awready), .o_wready(wready), .o_bvalid(bvalid),
    .o_bresp(bresp), .o_arready(arready), .o_rvalid(rvalid),
    .o_rdata(rdat), .o_rresp(rresp), .o_irq(irq), .o_fault_line(fault));
  fpx_props #(.REVISION(REV)) fpx_props_i (.i_clk(i_clk),
    .i_resetn(i_resetn), .req(link.req), .op(link.op), .idx(link.idx),
    .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
    .irq(link.irq));

  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // control-word loads seen on the link and arithmetic starts seen on the device go output
  always @(posedge i_clk)
  begin
    if (link.req && !link.ack && link.op == fpx_pkg::OP_LOAD_CTX)
      loads.push_back(link.wdata);
    if (go === 1'b1)
      n_go++;
  end

  // ------
  // bus tasks
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [8:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    r = 2'h3;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdat <= d;
    for (int n = 0; n < 100 && r === 2'h3; n++)
    begin
      @(posedge i_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        r = bresp;
    end
  endtask

  task automatic axi_rd(input logic [8:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    r = 2'h3;
    d = 32'h0;
    arvalid <= 1'b1;
    araddr <= a;
    for (int n = 0; n < 100 && r === 2'h3; n++)
    begin
      @(posedge i_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdat;
        r = rresp;
      end
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk(32'(r), 32'(fpx_pkg::RESP_OK));
  endtask

  task automatic rd(input logic [8:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(32'(r), 32'(fpx_pkg::RESP_OK));
  endtask

  task automatic run(input logic [2:0] start, input logic [3:0] op,
                     input logic [4:0] ix);
    logic [31:0] s;
    wr(fpx_pkg::A_CTRL, {19'h0, ix, op, 1'b0, start});
    s = 32'h1;
    for (int n = 0; n < 300 && s[0] !== 1'b0; n++)
      rd(fpx_pkg::A_STATUS, s);
    chk(32'(s[0]), 32'h0);
  endtask

  task automatic cmd(input logic [3:0] op, input logic [4:0] ix,
                     input logic [31:0] d);
    wr(fpx_pkg::A_WDATA, d);
    run(fpx_pkg::GO_CMD, op, ix);
  endtask

  task automatic ctx(output logic [31:0] d);
    cmd(fpx_pkg::OP_STORE_CTX, 5'h00, 32'h0);
    rd(fpx_pkg::A_RDATA, d);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge i_clk);
    n_errors++;
    end_sim();
  end

  // ------
  // tests
  // ------
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [31:0] seq[6];
    logic [3:0]  ops[3];
    int          k;
    i_resetn = 1'b0;
    exc = 8'h00;
    other = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 9'h000;
    araddr = 9'h000;
    wdat = 32'h0;
    n_errors = 0;
    cmp_count = 0;
    n_go = 0;
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    axi_wr(9'h040, 32'h1, r);
    chk(32'(r), 32'(fpx_pkg::RESP_ERR));
    axi_rd(9'h044, d, r);
    chk(32'(r), 32'(fpx_pkg::RESP_ERR));
    chk(d, 32'h0);
    $display("test unmapped done");
    wr(fpx_pkg::A_WDATA, 32'hC3C3_3C3C);
    run(fpx_pkg::GO_DET, 4'h0, 5'h00);
    rd(fpx_pkg::A_STATUS, d);
    chk(32'(d[1]), 32'h1);
    rd(fpx_pkg::A_WDATA, d);
    chk(d, 32'hC3C3_3C3C);
    loads.delete();
    run(fpx_pkg::GO_INIT, 4'h0, 5'h00);
    seq = '{fpx_pkg::W_PROBE, fpx_pkg::W_BOTH, fpx_pkg::W_TAIL0,
            fpx_pkg::W_TAIL1, fpx_pkg::W_TAIL2, fpx_pkg::W_SAFE};
    chk(32'(loads.size()), 32'h6);
    for (int i = 0; i < 6; i++)
      chk(loads[i], seq[i]);
    rd(fpx_pkg::A_STATUS, d);
    chk(32'(d[31:16]), 32'(REV));
    ctx(d);
    chk(d, fpx_pkg::W_SAFE);
    $display("test detect and init done");
    wr(fpx_pkg::A_IMASK, 32'h3);
    cmd(fpx_pkg::OP_LOAD_CTX, 5'h00, 32'h0);
    exc <= 8'h04;
    @(posedge i_clk);
    exc <= 8'h00;
    repeat (4) @(posedge i_clk);
    chk(32'(link.irq), 32'h1);
    chk(32'(fault), 32'h1);
    rd(fpx_pkg::A_ISTAT, d);
    chk(32'(d[1]), 32'h1);
    chk(32'(d[0]), 32'h1);
    chk(32'(irq), 32'h1);
    cmd(fpx_pkg::OP_LOAD_CTX, 5'h00, 32'h0004_0400);
    chk(32'(link.irq), 32'h0);
    ctx(d);
    chk(32'(d[15:8]), 32'h4);
    cmd(fpx_pkg::OP_LOAD_CTX, 5'h00, 32'h0000_0400);
    chk(32'(link.irq), 32'h1);
    cmd(fpx_pkg::OP_LOAD_CTX, 5'h00, 32'h0);
    chk(32'(link.irq), 32'h0);
    other <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk(32'(fault), 32'h1);
    rd(fpx_pkg::A_STATUS, d);
    chk(32'(d[2]), 32'h1);
    other <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk(32'(fault), 32'h0);
    wr(fpx_pkg::A_IMASK, 32'h0);
    chk(32'(irq), 32'h0);
    wr(fpx_pkg::A_IMASK, 32'h3);
    chk(32'(irq), 32'h1);
    wr(fpx_pkg::A_ISTAT, 32'h3);
    rd(fpx_pkg::A_ISTAT, d);
    chk(d, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test exceptions done");
    ops = '{fpx_pkg::OP_SQRT, fpx_pkg::OP_RSUB, fpx_pkg::OP_DMAC};
    foreach (ops[i])
    begin
      k = n_go;
      cmd(ops[i], 5'h00, 32'h0);
      chk(n_go, k + 1);
      chk(32'(go_op), 32'(ops[i]));
    end
    ctx(d);
    chk(32'(d[15:8]), 32'h0);
    cmd(4'hF, 5'h00, 32'h0);
    ctx(d);
    chk(32'(d[8]), 32'h1);
    $display("test operations done");
    cmd(fpx_pkg::OP_TO_REG, fpx_pkg::REG_ONE, 32'h1234_5678);
    cmd(fpx_pkg::OP_FROM_REG, fpx_pkg::REG_ONE, 32'h0);
    rd(fpx_pkg::A_RDATA, d);
    chk(d, 32'h1234_5678);
    cmd(fpx_pkg::OP_TO_REG, 5'h05, 32'hA5A5_0005);
    cmd(fpx_pkg::OP_LOAD_CTX, 5'h00, 32'h00FF_0100);
    run(fpx_pkg::GO_SAVE, 4'h0, 5'h00);
    rd(fpx_pkg::A_BUF + 9'h014, d);
    chk(d, 32'hA5A5_0005);
    rd(fpx_pkg::A_BUF + 9'h080, d);
    chk(d, 32'h00FF_0100);
    wr(fpx_pkg::A_BUF + 9'h01C, 32'h5A5A_0007);
    run(fpx_pkg::GO_REST, 4'h0, 5'h00);
    cmd(fpx_pkg::OP_FROM_REG, 5'h07, 32'h0);
    rd(fpx_pkg::A_RDATA, d);
    chk(d, 32'h5A5A_0007);
    ctx(d);
    chk(d, fpx_pkg::W_SAFE);
    $display("test context done");
    end_sim();
  end
endmodule // test_fpu_exception_context_control
`default_nettype wire
